// File: rtl/gpcn_pkg.sv
package gpcn_pkg;
  // Register bus
  localparam int GPCN_AW = 16;
  localparam int GPCN_DW = 32;
  localparam int GPCN_HALF = 16;
  // Port registers, each with clear/set/invert aliases at +4/+8/+C
  localparam logic [15:0] OFF_PIN_DIRECTION = 16'h2EC0;
  localparam logic [15:0] OFF_PIN_LEVEL = 16'h2ED0;
  localparam logic [15:0] OFF_OUTPUT_LATCH = 16'h2EE0;
  localparam logic [15:0] OFF_OPEN_DRAIN_SELECT = 16'h2EF0;
  localparam logic [15:0] OFF_PULL_UP_ENABLE = 16'h2F00;
  localparam logic [15:0] OFF_PULL_DOWN_ENABLE = 16'h2F10;
  localparam logic [15:0] OFF_CHANGE_NOTIFY_CONTROL = 16'h2F20;
  localparam logic [15:0] OFF_CHANGE_ENABLE_ZERO = 16'h2F30;
  localparam logic [15:0] OFF_CHANGE_MISMATCH_STATUS = 16'h2F40;
  localparam logic [15:0] OFF_CHANGE_ENABLE_ONE = 16'h2F50;
  localparam logic [15:0] OFF_CHANGE_EDGE_FLAGS = 16'h2F60;
  localparam logic [15:0] OFF_SLEW_SELECT_ZERO = 16'h2F70;
  localparam logic [15:0] OFF_SLEW_SELECT_ONE = 16'h2F80;
  // Interrupt status and mask
  localparam logic [15:0] OFF_IRQ_STATUS = 16'h2F90;
  localparam logic [15:0] OFF_IRQ_MASK = 16'h2FA0;
  // Alias field of the address
  localparam int ALIAS_LSB = 2;
  typedef enum logic [1:0] {
    GPCN_OP_WRITE = 2'b00,
    GPCN_OP_CLEAR = 2'b01,
    GPCN_OP_SET = 2'b10,
    GPCN_OP_INVERT = 2'b11
  } gpcn_op_e;
  // Change notification control fields
  localparam int CTL_ON_BIT = 15;
  localparam int CTL_STYLE_BIT = 11;
  localparam int CTL_MERGE_BIT = 10;
  localparam logic [15:0] CTL_IMPL_MASK = 16'h8C00;
  // Reset values
  localparam logic [15:0] DIR_RST = 16'h030F;
  localparam logic [15:0] DIR_FIXED_ONES = 16'h0300;
  localparam logic [15:0] REG_RST = 16'h0000;
  // Implemented pins per package variant
  localparam logic [3:0] IMPL_PINS_LARGE = 4'hF;
  localparam logic [3:0] IMPL_PINS_MID = 4'h1;
  localparam logic [3:0] IMPL_PINS_SMALL = 4'h0;
  localparam int IRQ_CN_BIT = 0;
endpackage

// File: rtl/gpcn_pin_if.sv
interface gpcn_pin_if #(parameter int N = 4);
  logic [N-1:0] dir;
  logic [N-1:0] lat;
  logic [N-1:0] odc;
  logic [N-1:0] pu;
  logic [N-1:0] pd;
  logic [N-1:0] sr0;
  logic [N-1:0] sr1;
  logic [N-1:0] pin;
  logic [N-1:0] rise;
  logic [N-1:0] fall;
  modport core (output dir, lat, odc, pu, pd, sr0, sr1, input pin, rise, fall);
  modport bank (input dir, lat, odc, pu, pd, sr0, sr1, output pin, rise, fall);
endinterface

// File: rtl/gpcn_pin_bank.sv
module gpcn_pin_bank #(
  parameter int N = 4
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  // Core side
  gpcn_pin_if.bank pin_if,
  // Pads
  input wire logic [N-1:0] i_pad_in,
  output logic [N-1:0] o_pad_out,
  output logic [N-1:0] o_pad_oe,
  output logic [N-1:0] o_pull_up,
  output logic [N-1:0] o_pull_down,
  output logic [N-1:0] o_slew_zero,
  output logic [N-1:0] o_slew_one
);
  import gpcn_pkg::*;

  typedef struct packed {
    logic [N-1:0] meta;
    logic [N-1:0] pin;
    logic [N-1:0] prev;
    logic [N-1:0] out;
    logic [N-1:0] oe;
    logic [N-1:0] pu;
    logic [N-1:0] pd;
    logic [N-1:0] sr0;
    logic [N-1:0] sr1;
  } gpcn_bank_s;

  gpcn_bank_s st_r;
  gpcn_bank_s st_nxt;

  always_comb
  begin
    st_nxt = st_r;
    // First stage feeds only the second
    st_nxt.meta = i_pad_in;
    st_nxt.pin = st_r.meta;
    st_nxt.prev = st_r.pin;
    st_nxt.out = pin_if.lat;
    // Open drain only pulls low; a latch one releases the pad
    st_nxt.oe = ~pin_if.dir & ~(pin_if.odc & pin_if.lat);
    st_nxt.pu = pin_if.pu;
    st_nxt.pd = pin_if.pd;
    st_nxt.sr0 = pin_if.sr0;
    st_nxt.sr1 = pin_if.sr1;
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign pin_if.pin = st_r.pin;
  assign pin_if.rise = st_r.pin & ~st_r.prev;
  assign pin_if.fall = ~st_r.pin & st_r.prev;
  assign o_pad_out = st_r.out;
  assign o_pad_oe = st_r.oe;
  assign o_pull_up = st_r.pu;
  assign o_pull_down = st_r.pd;
  assign o_slew_zero = st_r.sr0;
  assign o_slew_one = st_r.sr1;

  chk_pad_drive: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // R10
    1'b1 |=> o_pad_oe == (~$past(pin_if.dir) & ~($past(pin_if.odc) & $past(pin_if.lat))))
    else $error("pad enable does not follow direction and latch");
endmodule

// File: rtl/gpcn_port.sv
// How it works
// R1: Each port register also answers at +4, +8 and +C, where a write clears, sets or inverts only the one bits.
// R2: Control bit 15 turns change detection on; with it clear no change events arise.
// R3: With the style bit 11 set, enabled pin edges set per-pin edge flags.
// R4: With the style bit clear, pins are compared with the levels caught at the last level read.
// R5: With the merge bit 10 set, the upper half-word of each port register reaches the next higher port.
// R6: Reset loads 030F into the direction register and zero into every other register.
// R7: A pin-count parameter removes pins 3..1 in the mid variant and all pins in the small variant.
// R8: Unimplemented bits, including control bits 14..12 and 9..0, read as zero and ignore writes.
// R9: One change event goes to the interrupt logic when detection is on and an enabled pin flags.
// R10: Output pins drive the latch, level reads return synchronised pins and level writes update the latch.
//
// Local design decision: the plain strobed port.
module gpcn_port #(
  parameter logic [3:0] IMPL_MASK = gpcn_pkg::IMPL_PINS_LARGE
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  // Register port
  input wire logic [gpcn_pkg::GPCN_AW-1:0] i_addr,
  input wire logic [gpcn_pkg::GPCN_DW-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [gpcn_pkg::GPCN_DW-1:0] o_rdata,
  // Next higher port, used while merged
  output logic o_nb_wr,
  output logic [gpcn_pkg::GPCN_AW-1:0] o_nb_addr,
  output logic [gpcn_pkg::GPCN_HALF-1:0] o_nb_wdata,
  input wire logic [gpcn_pkg::GPCN_HALF-1:0] i_nb_rdata,
  // Pads
  input wire logic [3:0] i_pad_in,
  output logic [3:0] o_pad_out,
  output logic [3:0] o_pad_oe,
  output logic [3:0] o_pull_up,
  output logic [3:0] o_pull_down,
  output logic [3:0] o_slew_zero,
  output logic [3:0] o_slew_one,
  // Interrupt
  output logic o_irq
);
  import gpcn_pkg::*;

  localparam int N = 4;
  localparam logic [N-1:0] DIR_RST_N = DIR_RST[N-1:0] & IMPL_MASK;

  typedef struct packed {
    logic [N-1:0] dir;
    logic [N-1:0] lat;
    logic [N-1:0] odc;
    logic [N-1:0] pu;
    logic [N-1:0] pd;
    logic [N-1:0] en0;
    logic [N-1:0] en1;
    logic [N-1:0] flg;
    logic [N-1:0] stat;
    logic [N-1:0] sr0;
    logic [N-1:0] sr1;
    logic [N-1:0] snap;
    logic on;
    logic style;
    logic merge;
    logic irq_st;
    logic irq_mask;
    logic [GPCN_DW-1:0] rd_data;
  } gpcn_core_s;

  logic rst_meta_r;
  logic rst_n;
  gpcn_core_s s_r;
  gpcn_core_s s_nxt;
  logic [GPCN_AW-1:0] base;
  gpcn_op_e op;
  logic port_hit;
  logic [N-1:0] wl;
  logic [N-1:0] pins;
  logic [N-1:0] flg_set;
  logic [N-1:0] stat_calc;
  logic cn_event;
  logic [15:0] ctl_word;
  logic [15:0] ctl_new;
  logic [15:0] rd_lo;

  gpcn_pin_if #(.N(N)) pin_if ();

  // Release of the reset is synchronised; assertion stays asynchronous
  always_ff @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      rst_meta_r <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta_r <= 1'b1;
      rst_n <= rst_meta_r;
    end
  end

  function automatic logic [15:0] alu(input logic [15:0] cur, input logic [15:0] wd, input gpcn_op_e o);
    case (o)
      GPCN_OP_WRITE: alu = wd;
      GPCN_OP_CLEAR: alu = cur & ~wd;
      GPCN_OP_SET: alu = cur | wd;
      GPCN_OP_INVERT: alu = cur ^ wd;
      default: alu = cur;
    endcase
  endfunction

  function automatic logic [N-1:0] upd(input logic [N-1:0] cur, input logic [N-1:0] wd, input gpcn_op_e o);
    logic [15:0] r;
    r = alu(16'(cur), 16'(wd), o);
    upd = r[N-1:0] & IMPL_MASK;
  endfunction

  // R1: alias decode
  assign base = {i_addr[GPCN_AW-1:4], 4'h0};
  assign op = gpcn_op_e'(i_addr[ALIAS_LSB+1:ALIAS_LSB]);
  assign port_hit = (base >= OFF_PIN_DIRECTION) && (base <= OFF_SLEW_SELECT_ONE);
  // R7: absent pins never store anything
  assign wl = i_wdata[N-1:0] & IMPL_MASK;
  assign pins = pin_if.pin & IMPL_MASK;

  always_comb
  begin
    ctl_word = 16'h0000;
    ctl_word[CTL_ON_BIT] = s_r.on;
    ctl_word[CTL_STYLE_BIT] = s_r.style;
    ctl_word[CTL_MERGE_BIT] = s_r.merge;
  end

  // R8: only ON, style and merge bits take writes
  assign ctl_new = alu(ctl_word, i_wdata[15:0], op) & CTL_IMPL_MASK;

  // R2: detection off blocks every flag and status bit
  // R3: edge style flags on enabled rising or falling edges
  assign flg_set = (s_r.on && s_r.style) ? ((s_r.en1 & pin_if.rise) | (s_r.en0 & pin_if.fall)) & IMPL_MASK : '0;
  // R4: mismatch against the snapshot of the last level read
  assign stat_calc = (s_r.on && !s_r.style) ? (s_r.en0 & (pins ^ s_r.snap)) : '0;
  // R9: one event when any enabled pin newly flags
  assign cn_event = s_r.on && (s_r.style ? |(flg_set & ~s_r.flg) : |(stat_calc & ~s_r.stat));

  always_comb
  begin
    case (base)
      OFF_PIN_DIRECTION: rd_lo = DIR_FIXED_ONES | 16'(s_r.dir);
      // R10: level reads return synchronised pins
      OFF_PIN_LEVEL: rd_lo = 16'(pins);
      OFF_OUTPUT_LATCH: rd_lo = 16'(s_r.lat);
      OFF_OPEN_DRAIN_SELECT: rd_lo = 16'(s_r.odc);
      OFF_PULL_UP_ENABLE: rd_lo = 16'(s_r.pu);
      OFF_PULL_DOWN_ENABLE: rd_lo = 16'(s_r.pd);
      OFF_CHANGE_NOTIFY_CONTROL: rd_lo = ctl_word;
      OFF_CHANGE_ENABLE_ZERO: rd_lo = 16'(s_r.en0);
      OFF_CHANGE_MISMATCH_STATUS: rd_lo = 16'(s_r.stat);
      OFF_CHANGE_ENABLE_ONE: rd_lo = 16'(s_r.en1);
      OFF_CHANGE_EDGE_FLAGS: rd_lo = 16'(s_r.flg);
      OFF_SLEW_SELECT_ZERO: rd_lo = 16'(s_r.sr0);
      OFF_SLEW_SELECT_ONE: rd_lo = 16'(s_r.sr1);
      OFF_IRQ_STATUS: rd_lo = 16'(s_r.irq_st);
      OFF_IRQ_MASK: rd_lo = 16'(s_r.irq_mask);
      default: rd_lo = REG_RST;
    endcase
  end

  always_comb
  begin
    s_nxt = s_r;
    s_nxt.rd_data = '0;
    if (i_wr)
    begin
      case (base)
        OFF_PIN_DIRECTION: s_nxt.dir = upd(s_r.dir, wl, op);
        // R10: level writes land in the latch
        OFF_PIN_LEVEL: s_nxt.lat = upd(s_r.lat, wl, op);
        OFF_OUTPUT_LATCH: s_nxt.lat = upd(s_r.lat, wl, op);
        OFF_OPEN_DRAIN_SELECT: s_nxt.odc = upd(s_r.odc, wl, op);
        OFF_PULL_UP_ENABLE: s_nxt.pu = upd(s_r.pu, wl, op);
        OFF_PULL_DOWN_ENABLE: s_nxt.pd = upd(s_r.pd, wl, op);
        OFF_CHANGE_NOTIFY_CONTROL:
        begin
          s_nxt.on = ctl_new[CTL_ON_BIT];
          s_nxt.style = ctl_new[CTL_STYLE_BIT];
          s_nxt.merge = ctl_new[CTL_MERGE_BIT];
        end
        OFF_CHANGE_ENABLE_ZERO: s_nxt.en0 = upd(s_r.en0, wl, op);
        OFF_CHANGE_ENABLE_ONE: s_nxt.en1 = upd(s_r.en1, wl, op);
        OFF_CHANGE_EDGE_FLAGS: s_nxt.flg = upd(s_r.flg, wl, op);
        OFF_SLEW_SELECT_ZERO: s_nxt.sr0 = upd(s_r.sr0, wl, op);
        OFF_SLEW_SELECT_ONE: s_nxt.sr1 = upd(s_r.sr1, wl, op);
        OFF_IRQ_MASK:
        begin
          s_nxt.irq_mask = |(alu(16'(s_r.irq_mask), i_wdata[15:0], op) & 16'h0001);
        end
        default:
        begin
        end
      endcase
    end
    // A flag raised while software clears it survives
    s_nxt.flg = s_nxt.flg | flg_set;
    s_nxt.stat = stat_calc;
    if (i_rd)
    begin
      // R5: upper half belongs to the next port only while merged
      s_nxt.rd_data = {(s_r.merge && port_hit) ? i_nb_rdata : REG_RST, rd_lo};
      if (base == OFF_PIN_LEVEL)
        s_nxt.snap = pins;
    end
    if (i_rd && base == OFF_IRQ_STATUS)
      s_nxt.irq_st = 1'b0;
    s_nxt.irq_st = s_nxt.irq_st | cn_event;
  end

  // R6: direction resets to inputs, everything else to zero
  always_ff @(posedge i_ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_r <= '0;
      s_r.dir <= DIR_RST_N;
    end
    else
      s_r <= s_nxt;
  end

  // R5: merged upper half-word goes through to the neighbour
  assign o_nb_wr = i_wr && s_r.merge && port_hit;
  assign o_nb_addr = i_addr;
  assign o_nb_wdata = i_wdata[31:16];

  // Absent pins stay inputs so they never drive
  assign pin_if.dir = s_r.dir | ~IMPL_MASK;
  assign pin_if.lat = s_r.lat;
  assign pin_if.odc = s_r.odc;
  assign pin_if.pu = s_r.pu;
  assign pin_if.pd = s_r.pd;
  assign pin_if.sr0 = s_r.sr0;
  assign pin_if.sr1 = s_r.sr1;
  assign o_rdata = s_r.rd_data;
  assign o_irq = s_r.irq_st & s_r.irq_mask;

  gpcn_pin_bank #(.N(N)) u_bank (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(rst_n),
    .pin_if(pin_if.bank),
    .i_pad_in(i_pad_in),
    .o_pad_out(o_pad_out),
    .o_pad_oe(o_pad_oe),
    .o_pull_up(o_pull_up),
    .o_pull_down(o_pull_down),
    .o_slew_zero(o_slew_zero),
    .o_slew_one(o_slew_one)
  );

  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!rst_n);

  chk_alias_set_latch: assert property ( // R1
    i_wr && base == OFF_OUTPUT_LATCH && op == GPCN_OP_SET |=> s_r.lat == ($past(s_r.lat) | $past(wl)))
    else $error("set alias did not OR into the latch");
  chk_alias_clr_latch: assert property ( // R1
    i_wr && base == OFF_OUTPUT_LATCH && op == GPCN_OP_CLEAR |=> (s_r.lat & $past(wl)) == '0)
    else $error("clear alias left a written bit set");
  chk_off_no_event: assert property ( // R2
    !s_r.on |=> s_r.stat == '0 && !$past(cn_event))
    else $error("change status while detection is off");
  chk_edge_flag_set: assert property ( // R3
    s_r.on && s_r.style && |(s_r.en1 & pin_if.rise & IMPL_MASK) |=> |s_r.flg)
    else $error("enabled rising edge did not set a flag");
  chk_mismatch_status: assert property ( // R4
    s_r.on && !s_r.style |=> s_r.stat == ($past(s_r.en0) & ($past(pins) ^ $past(s_r.snap))))
    else $error("mismatch status wrong");
  chk_merge_upper_zero: assert property ( // R5
    i_rd && !s_r.merge |=> o_rdata[31:16] == 16'h0000)
    else $error("upper half not zero while unmerged");
  chk_reset_direction: assert property ( // R6
    $rose(rst_n) |-> s_r.dir == DIR_RST_N && s_r.lat == '0 && !s_r.on)
    else $error("reset values wrong");
  chk_absent_pins: assert property ( // R7
    ((s_r.lat | s_r.flg | s_r.en0) & ~IMPL_MASK) == '0)
    else $error("absent pin bit stored");
  chk_ctl_read_mask: assert property ( // R8
    i_rd && base == OFF_CHANGE_NOTIFY_CONTROL |=> (o_rdata[15:0] & ~CTL_IMPL_MASK) == 16'h0000
    && ($past(s_r.merge) || o_rdata[31:16] == 16'h0000))
    else $error("unimplemented control bit read as one");
  chk_event_irq: assert property ( // R9
    cn_event |=> s_r.irq_st && o_irq == s_r.irq_mask)
    else $error("change event did not raise the interrupt");
  chk_level_read: assert property ( // R10
    i_rd && base == OFF_PIN_LEVEL |=> o_rdata[N-1:0] == $past(pins))
    else $error("level read did not return synchronised pins");
  chk_alias_inv_latch: assert property ( // R1
    i_wr && base == OFF_OUTPUT_LATCH && op == GPCN_OP_INVERT |=> s_r.lat == ($past(s_r.lat) ^ $past(wl)))
    else $error("invert alias did not toggle the latch");
  chk_alias_wr_dir: assert property ( // R1
    i_wr && base == OFF_PIN_DIRECTION && op == GPCN_OP_WRITE |=> s_r.dir == $past(wl))
    else $error("direction write did not land");
  chk_pull_up_set: assert property ( // R1
    i_wr && base == OFF_PULL_UP_ENABLE && op == GPCN_OP_SET |=> s_r.pu == ($past(s_r.pu) | $past(wl)))
    else $error("set alias did not OR into the pull-up enables");
  chk_off_flags_hold: assert property ( // R2
    !s_r.on && !i_wr |=> s_r.flg == $past(s_r.flg))
    else $error("edge flag moved while detection is off");
  chk_ctl_on_clear: assert property ( // R2
    i_wr && base == OFF_CHANGE_NOTIFY_CONTROL && op == GPCN_OP_CLEAR && i_wdata[CTL_ON_BIT] |=> !s_r.on)
    else $error("clearing the enable left detection on");
  chk_edge_fall_set: assert property ( // R3
    s_r.on && s_r.style |=> (s_r.flg & $past(s_r.en0) & $past(pin_if.fall) & IMPL_MASK)
    == ($past(s_r.en0) & $past(pin_if.fall) & IMPL_MASK))
    else $error("enabled falling edge did not set its flag");
  chk_edge_no_status: assert property ( // R3
    s_r.on && s_r.style |=> s_r.stat == '0)
    else $error("mismatch status set in edge style");
  chk_flag_sticky: assert property ( // R3
    !i_wr |=> (s_r.flg & $past(s_r.flg)) == $past(s_r.flg))
    else $error("edge flag dropped without a write");
  chk_mismatch_no_flag: assert property ( // R4
    s_r.on && !s_r.style && !i_wr |=> s_r.flg == $past(s_r.flg))
    else $error("edge flag moved in mismatch style");
  chk_snap_on_read: assert property ( // R4
    i_rd && base == OFF_PIN_LEVEL |=> s_r.snap == $past(pins))
    else $error("level read did not capture the pins");
  chk_merge_nb_write: assert property ( // R5
    i_wr && s_r.merge && base == OFF_OUTPUT_LATCH |-> o_nb_wr && o_nb_wdata == i_wdata[31:16] && o_nb_addr == i_addr)
    else $error("merged write not passed to the next port");
  chk_merge_upper_read: assert property ( // R5
    i_rd && s_r.merge && port_hit |=> o_rdata[31:16] == $past(i_nb_rdata))
    else $error("merged read upper half is not the next port");
  chk_dir_read_fixed: assert property ( // R6
    i_rd && base == OFF_PIN_DIRECTION |=> o_rdata[9:8] == 2'b11)
    else $error("direction fixed bits not read as one");
  chk_unmapped_read: assert property ( // R8
    i_rd && (base < OFF_PIN_DIRECTION || base > OFF_IRQ_MASK) |=> o_rdata == '0)
    else $error("unmapped address read as nonzero");
  chk_irq_clear_read: assert property ( // R9
    i_rd && base == OFF_IRQ_STATUS && !cn_event |=> !s_r.irq_st)
    else $error("status read did not clear the interrupt");
  chk_irq_sticky: assert property ( // R9
    s_r.irq_st && !(i_rd && base == OFF_IRQ_STATUS) |=> s_r.irq_st)
    else $error("interrupt status dropped without a read");
  chk_level_write_latch: assert property ( // R10
    i_wr && base == OFF_PIN_LEVEL && op == GPCN_OP_WRITE |=> s_r.lat == $past(wl))
    else $error("level write did not land in the latch");
  chk_rdata_idle: assert property ( // R10
    !i_rd |=> o_rdata == '0)
    else $error("read data stands without a read");
endmodule

// File: testbench/gpcn_pin_model.sv
module gpcn_pin_model (
  // Clock
  input wire logic i_ref_clk,
  // Design pad outputs
  input wire logic [3:0] i_pad_out,
  input wire logic [3:0] i_pad_oe,
  input wire logic [3:0] i_pull_up,
  input wire logic [3:0] i_pull_down,
  // Board drivers
  input wire logic [3:0] i_ext_en,
  input wire logic [3:0] i_ext_val,
  // Resolved pin level
  output logic [3:0] o_pin
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] float_r = 4'h0;
  // An unheld line wanders, so a stale level never passes for a driven one
  always_ff @(posedge i_ref_clk)
  begin
    float_r <= ~float_r;
  end
  always_comb
  begin
    for (int i = 0; i < 4; i++)
    begin
      // pin follows the port driver first
      if (i_pad_oe[i])
        o_pin[i] = i_pad_out[i];
      else if (i_ext_en[i])
        o_pin[i] = i_ext_val[i];
      else if (i_pull_up[i])
        o_pin[i] = 1'b1;
      else if (i_pull_down[i])
        o_pin[i] = 1'b0;
      else
        o_pin[i] = float_r[i];
    end
  end
endmodule

// File: testbench/gpcn_port_tb.sv
module gpcn_port_tb;
  import gpcn_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [31:0] wdata = 32'h00000000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [15:0] nb = 16'h0000;
  logic [3:0] ext_en = 4'hF;
  logic [3:0] ext_val = 4'h0;
  logic [31:0] rdata;
  logic nb_wr;
  logic [15:0] nb_addr;
  logic [15:0] nb_wdata;
  logic [3:0] pad_in;
  logic [3:0] pad_out;
  logic [3:0] pad_oe;
  logic [3:0] pu;
  logic [3:0] pd;
  logic [3:0] sr0;
  logic [3:0] sr1;
  logic irq;
  int failures = 0;
  int n_compared = 0;
  int seed = 48;
  logic [31:0] m [16];
  logic [3:0] r;

  gpcn_port uut (.i_ref_clk(ref_clk), .i_arst_n(arst_n), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
    .i_rd(rd), .o_rdata(rdata), .o_nb_wr(nb_wr), .o_nb_addr(nb_addr), .o_nb_wdata(nb_wdata), .i_nb_rdata(nb),
    .i_pad_in(pad_in), .o_pad_out(pad_out), .o_pad_oe(pad_oe), .o_pull_up(pu), .o_pull_down(pd),
    .o_slew_zero(sr0), .o_slew_one(sr1), .o_irq(irq));
  gpcn_pin_model pins (.i_ref_clk(ref_clk), .i_pad_out(pad_out), .i_pad_oe(pad_oe), .i_pull_up(pu),
    .i_pull_down(pd), .i_ext_en(ext_en), .i_ext_val(ext_val), .o_pin(pad_in));

  initial
  begin
    forever #2 ref_clk = ~ref_clk;
  end

  task automatic wrap_up;
    if (failures == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      failures++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask

  function automatic logic [31:0] mk(input int i);
    case (i)
      6: mk = 32'h00008C00;
      8, 13, 15: mk = 32'h00000000;
      14: mk = 32'h00000001;
      default: mk = 32'h0000000F;
    endcase
  endfunction

  // Expected read value of register slot i
  function automatic logic [31:0] ex(input int i);
    logic [31:0] v;
    logic [3:0] dv;
    v = m[i];
    dv = ~m[0][3:0] & ~(m[3][3:0] & m[2][3:0]);
    if (i == 0)
      v = v | 32'h00000300;
    if (i == 1)
      v = {28'h0, (dv & m[2][3:0]) | (~dv & ext_val)};
    if (m[6][10] && i < 13)
      v[31:16] = nb;
    ex = v;
  endfunction

  task automatic wr_reg(input logic [15:0] a, input logic [31:0] d);
    int i;
    logic [31:0] v;
    i = int'((a - 16'h2EC0) >> 4);
    if (i == 1)
      i = 2;
    v = d & mk(i);
    @(posedge ref_clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    #1;
    chk("nb_wr", {31'h0, m[6][10] && a < OFF_IRQ_STATUS}, {31'h0, nb_wr});
    chk("nb_wdata", {16'h0, d[31:16]}, {16'h0, nb_wdata});
    chk("nb_addr", {16'h0, a}, {16'h0, nb_addr});
    @(posedge ref_clk);
    wr <= 1'b0;
    case (a[3:2])
      2'h0: m[i] = v;
      2'h1: m[i] = m[i] & ~v;
      2'h2: m[i] = m[i] | v;
      default: m[i] = m[i] ^ v;
    endcase
  endtask

  task automatic rd_reg(input logic [15:0] a, input logic [31:0] e);
    @(posedge ref_clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1;
    chk($sformatf("read %h", a), e, rdata);
  endtask

  task automatic chk_pads;
    repeat (2) @(posedge ref_clk);
    #1;
    chk("pad_out", m[2], {28'h0, pad_out});
    chk("pad_oe", {28'h0, ~m[0][3:0] & ~(m[3][3:0] & m[2][3:0])}, {28'h0, pad_oe});
    chk("pulls", {m[4][3:0], m[5][3:0]}, {24'h0, pu, pd});
    chk("slew", {m[11][3:0], m[12][3:0]}, {24'h0, sr0, sr1});
  endtask

  task automatic irq_is(input logic e);
    @(posedge ref_clk);
    #1;
    chk("irq", {31'h0, e}, {31'h0, irq});
  endtask

  initial
  begin
    repeat (5000) @(posedge ref_clk);
    failures++;
    wrap_up();
  end

  initial
  begin
    for (int k = 0; k < 16; k++)
      m[k] = 32'h00000000;
    m[0] = 32'h0000000F;
    nb = 16'($random(seed));
    repeat (6) @(posedge ref_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    for (int i = 0; i < 16; i++)
      rd_reg(16'h2EC0 + 16'(i * 16), ex(i));
    // Every alias of every plain register below the interrupt mask, read-only ones included
    for (int i = 0; i < 14; i++)
      for (int op = 0; op < 4; op++)
        if (i != 6 && i != 10)
        begin
          wr_reg(16'h2EC0 + 16'(i * 16 + op * 4), $random(seed));
          chk_pads();
          rd_reg(16'h2EC0 + 16'(i * 16), ex(i));
        end
    // Driven pins, pin 1 open drain and released
    wr_reg(16'h2EC4, 32'h0000000F);
    wr_reg(16'h2EE0, 32'h0000000A);
    wr_reg(16'h2EF0, 32'h00000002);
    chk_pads();
    rd_reg(OFF_PIN_LEVEL, ex(1));
    wr_reg(16'h2EC8, 32'h0000000F);
    wr_reg(16'h2EF4, 32'h0000000F);
    rd_reg(OFF_PIN_LEVEL, ex(1));
    // Control keeps only its three bits; merge brings in the neighbour
    wr_reg(OFF_CHANGE_NOTIFY_CONTROL, 32'hFFFFFFFF);
    rd_reg(OFF_CHANGE_NOTIFY_CONTROL, ex(6));
    rd_reg(OFF_OUTPUT_LATCH, ex(2));
    wr_reg(16'h2F24, 32'hFFFFFFFF);
    // Rising edges, interrupt masked first
    wr_reg(OFF_CHANGE_ENABLE_ONE, 32'h0000000F);
    wr_reg(OFF_CHANGE_ENABLE_ZERO, 32'h00000000);
    wr_reg(OFF_IRQ_MASK, 32'h00000000);
    wr_reg(OFF_CHANGE_NOTIFY_CONTROL, 32'h00008800);
    r = 4'($random(seed)) | 4'h1;
    ext_val <= r;
    repeat (6) @(posedge ref_clk);
    rd_reg(OFF_CHANGE_EDGE_FLAGS, {28'h0, r});
    irq_is(1'b0);
    wr_reg(16'h2FA8, 32'h00000001);
    irq_is(1'b1);
    rd_reg(OFF_IRQ_STATUS, 32'h00000001);
    irq_is(1'b0);
    rd_reg(OFF_IRQ_STATUS, 32'h00000000);
    // Falling edges
    wr_reg(OFF_CHANGE_ENABLE_ONE, 32'h00000000);
    wr_reg(OFF_CHANGE_ENABLE_ZERO, 32'h0000000F);
    wr_reg(16'h2F64, 32'h0000000F);
    ext_val <= 4'h0;
    repeat (6) @(posedge ref_clk);
    rd_reg(OFF_CHANGE_EDGE_FLAGS, {28'h0, r});
    rd_reg(OFF_IRQ_STATUS, 32'h00000001);
    // Detection switched off
    wr_reg(16'h2F24, 32'h00008000);
    wr_reg(16'h2F64, 32'h0000000F);
    ext_val <= 4'hF;
    repeat (6) @(posedge ref_clk);
    rd_reg(OFF_CHANGE_EDGE_FLAGS, 32'h00000000);
    rd_reg(OFF_IRQ_STATUS, 32'h00000000);
    // Mismatch against the level caught at the last read
    wr_reg(OFF_CHANGE_NOTIFY_CONTROL, 32'h00008000);
    rd_reg(OFF_PIN_LEVEL, ex(1));
    rd_reg(OFF_IRQ_STATUS, 32'h00000001);
    r = 4'($random(seed)) & 4'h7;
    ext_val <= r;
    repeat (6) @(posedge ref_clk);
    rd_reg(OFF_CHANGE_MISMATCH_STATUS, {28'h0, ~r});
    rd_reg(OFF_IRQ_STATUS, 32'h00000001);
    wrap_up();
  end
endmodule
